// [flash_array_model.sv]
module flash_array_model (
    input  wire logic        clk,
    input  wire logic        rd,
    input  wire logic        prog,
    input  wire logic        erase,
    input  wire logic [14:0] addr,
    input  wire logic [13:0] wdata,
    output logic      [13:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] cells [logic [14:0]];
    initial rdata = 14'h0000;
    // word valid only the cycle after a request, churns otherwise
    always @(posedge clk)
    begin
        if (rd)
            rdata <= cells.exists(addr) ? cells[addr] : 14'h3FFF;
        else
            rdata <= ~rdata;
        if (prog)
            cells[addr] = (cells.exists(addr) ? cells[addr] : 14'h3FFF) & wdata;
        if (erase)
            for (int i = 0; i < 32; i++)
                cells[{addr[14:5], 5'(i)}] = 14'h3FFF;
    end
endmodule : flash_array_model

// [flash_self_program_sequencer.sv]
// The implementer's own choices: register access over APB and the address map.
`include "flash_seq_map.svh"

// Function
// - program memory rows of 14-bit words
// - refuse erase/program in protected segments
// - write data only through hidden latches
// - row and latch block: 32 aligned words
// - array read second cycle, data next
// - data pair holds read until overwritten
// - reads ignore code-protect setting
// - erase select stays set until erase done or refused
// - two setup cycles after write strobe
// - erase stalls cpu about 2 ms
// - programming never erases first
// - one write never crosses latch block
// - latches reset to 3FFF after write
// - latch-only: load latch, no stall
// - otherwise load last latch, program block
// - block program stalls cpu about 2 ms
// - latch load and program need unlock
// - write strobe needs write enable first
// - strobes set by software, cleared by hardware
// - completion sets write complete flag
// - unlock 55h, AAh, then strobe at once
module flash_self_program_sequencer
    import flash_seq_pkg::*;
#(
    parameter int OP_CYCLES = `NVM_OP_CYCLES,
    parameter int LATCHES   = `NVM_LATCH_COUNT
)(
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [1:0]  WRITE_PROTECT,
    input  wire logic        CODE_PROTECT,
    output logic             ARRAY_RD,
    output logic             ARRAY_PROG,
    output logic             ARRAY_ERASE,
    output logic      [14:0] ARRAY_ADDR,
    output logic      [13:0] ARRAY_WDATA,
    input  wire logic [13:0] ARRAY_RDATA,
    output logic             CPU_STALL
);
    localparam int LW = $clog2(LATCHES);
    seq_state_t   state_reg,  state_next;
    nvm_control_t ctl_reg,    ctl_next;
    logic [7:0]   addr_lo_reg, addr_lo_next;
    logic [6:0]   addr_hi_reg, addr_hi_next;
    logic [7:0]   data_lo_reg, data_lo_next;
    logic [5:0]   data_hi_reg, data_hi_next;
    logic [1:0]   unlock_reg,  unlock_next;
    logic         done_reg,    done_next;
    logic         refused_reg, refused_next;
    logic [31:0]  cnt_reg,     cnt_next;
    logic [31:0]  prdata_reg,  prdata_next;
    array_cmd_t   rd_cmd_reg,  rd_cmd_next;
    array_cmd_t   pg_cmd_reg,  pg_cmd_next;
    logic         erase_reg,   erase_next;
    logic [13:0]  latch_reg  [LATCHES];
    logic [13:0]  latch_next [LATCHES];
    logic [1:0]   wp_meta_reg, wp_sync_reg;
    logic         cp_meta_reg, cp_sync_reg;
    logic         wr_acc;
    logic         rd_phase;
    logic         mapped;
    logic [14:0]  full_addr;
    logic         protect_hit;
    nvm_control_t wr_ctl;
    assign full_addr = {addr_hi_reg, addr_lo_reg};
    assign wr_acc    = PSEL && PENABLE && PWRITE;
    assign rd_phase  = PSEL && !PENABLE;
    assign wr_ctl    = nvm_control_t'(PWDATA[7:0]);
    assign mapped    = (PADDR == `NVM_ADDR_LOW_OFS)  || (PADDR == `NVM_ADDR_HIGH_OFS) ||
                       (PADDR == `NVM_DATA_LOW_OFS)  || (PADDR == `NVM_DATA_HIGH_OFS) ||
                       (PADDR == `NVM_CONTROL_OFS)   || (PADDR == `NVM_UNLOCK_OFS)    ||
                       (PADDR == `NVM_STATUS_OFS);
    // write-protect decode on the synchronised field
    always_comb
    begin
        unique case (wp_sync_reg)
            2'h3:    protect_hit = 1'b0;
            2'h2:    protect_hit = full_addr < `NVM_WP_LOW_LIMIT;
            2'h1:    protect_hit = full_addr < `NVM_WP_HALF_LIMIT;
            default: protect_hit = 1'b1;
        endcase
    end
    assign PREADY      = 1'b1;
    assign PSLVERR     = PSEL && PENABLE && !mapped;
    assign PRDATA      = prdata_reg;
    assign ARRAY_RD    = rd_cmd_reg.valid;
    assign ARRAY_PROG  = pg_cmd_reg.valid;
    assign ARRAY_ERASE = erase_reg;
    assign ARRAY_ADDR  = rd_cmd_reg.valid ? rd_cmd_reg.addr : pg_cmd_reg.addr;
    assign ARRAY_WDATA = pg_cmd_reg.data;
    assign CPU_STALL   = (state_reg == ST_ERASE) || (state_reg == ST_PROG);

    always_comb
    begin
        state_next   = state_reg;
        ctl_next     = ctl_reg;
        addr_lo_next = addr_lo_reg;
        addr_hi_next = addr_hi_reg;
        data_lo_next = data_lo_reg;
        data_hi_next = data_hi_reg;
        unlock_next  = unlock_reg;
        done_next    = done_reg;
        refused_next = refused_reg;
        cnt_next     = cnt_reg;
        prdata_next  = prdata_reg;
        rd_cmd_next  = '0;
        pg_cmd_next  = pg_cmd_reg;
        pg_cmd_next.valid = 1'b0;
        erase_next   = 1'b0;
        latch_next   = latch_reg;

        // read data prepared in setup phase
        if (rd_phase)
        begin
            unique case (PADDR)
                `NVM_ADDR_LOW_OFS:  prdata_next = {24'h000000, addr_lo_reg};
                `NVM_ADDR_HIGH_OFS: prdata_next = {25'h0, addr_hi_reg};
                `NVM_DATA_LOW_OFS:  prdata_next = {24'h000000, data_lo_reg};
                `NVM_DATA_HIGH_OFS: prdata_next = {26'h0, data_hi_reg};
                `NVM_CONTROL_OFS:   prdata_next = {24'h000000, ctl_reg};
                `NVM_STATUS_OFS:    prdata_next = {26'h0, cp_sync_reg, wp_sync_reg,
                                                   (state_reg != ST_IDLE), refused_reg, done_reg};
                default:            prdata_next = 32'h00000000;
            endcase
        end

        if (wr_acc)
        begin
            unlock_next = 2'h0;
            unique case (PADDR)
                `NVM_ADDR_LOW_OFS:  addr_lo_next = PWDATA[7:0];
                `NVM_ADDR_HIGH_OFS: addr_hi_next = PWDATA[6:0];
                `NVM_DATA_LOW_OFS:  data_lo_next = PWDATA[7:0];
                `NVM_DATA_HIGH_OFS: data_hi_next = PWDATA[5:0];
                `NVM_UNLOCK_OFS:
                begin
                    if (PWDATA[7:0] == `NVM_UNLOCK_FIRST)
                        unlock_next = 2'h1;
                    else if (PWDATA[7:0] == `NVM_UNLOCK_SECOND && unlock_reg == 2'h1)
                        unlock_next = 2'h2;
                end
                `NVM_STATUS_OFS:
                begin
                    if (PWDATA[`STS_COMPLETE_BIT])
                        done_next = 1'b0;
                    if (PWDATA[`STS_REFUSED_BIT])
                        refused_next = 1'b0;
                end
                `NVM_CONTROL_OFS:
                begin
                    ctl_next.write_enable_bit = wr_ctl.write_enable_bit;
                    if (state_reg == ST_IDLE)
                    begin
                        ctl_next.program_memory_select = wr_ctl.program_memory_select;
                        ctl_next.config_space_select   = wr_ctl.config_space_select;
                        ctl_next.latch_only_select     = wr_ctl.latch_only_select;
                        ctl_next.erase_select          = wr_ctl.erase_select;
                        // strobes can only be set here
                        ctl_next.read_strobe = wr_ctl.read_strobe;
                        ctl_next.write_strobe = wr_ctl.write_strobe &&
                            ctl_reg.write_enable_bit && unlock_reg == 2'h2;
                    end
                end
                default: ;
            endcase
        end

        unique case (state_reg)
            ST_IDLE:
            begin
                if (ctl_next.write_strobe)
                begin
                    if (ctl_next.program_memory_select && !ctl_next.config_space_select)
                    begin
                        state_next = ST_SETUP;
                        cnt_next   = 32'h0;
                    end
                    else
                        ctl_next.write_strobe = 1'b0;
                end
                else if (ctl_next.read_strobe)
                begin
                    // code protect is not consulted for reads
                    if (ctl_next.program_memory_select && !ctl_next.config_space_select)
                    begin
                        state_next        = ST_RD_ARRAY;
                        rd_cmd_next.valid = 1'b1;
                        rd_cmd_next.addr  = {addr_hi_next, addr_lo_next};
                    end
                    else
                        ctl_next.read_strobe = 1'b0;
                end
            end
            ST_RD_ARRAY:
                state_next = ST_RD_DONE;
            ST_RD_DONE:
            begin
                data_lo_next         = ARRAY_RDATA[7:0];
                data_hi_next         = ARRAY_RDATA[13:8];
                ctl_next.read_strobe = 1'b0;
                state_next           = ST_IDLE;
            end
            ST_SETUP:
            begin
                cnt_next = cnt_reg + 32'h1;
                if (cnt_reg == `NVM_SETUP_CYCLES - 1)
                begin
                    cnt_next = 32'h0;
                    if (ctl_reg.erase_select)
                    begin
                        if (protect_hit)
                        begin
                            refused_next          = 1'b1;
                            ctl_next.erase_select = 1'b0;
                            ctl_next.write_strobe = 1'b0;
                            state_next            = ST_IDLE;
                        end
                        else
                        begin
                            erase_next       = 1'b1;
                            pg_cmd_next.addr = {full_addr[14:LW], LW'(0)};
                            state_next       = ST_ERASE;
                        end
                    end
                    else
                    begin
                        latch_next[addr_lo_reg[LW-1:0]] = {data_hi_reg, data_lo_reg};
                        if (ctl_reg.latch_only_select)
                        begin
                            ctl_next.write_strobe = 1'b0;
                            state_next            = ST_IDLE;
                        end
                        else if (protect_hit)
                        begin
                            refused_next          = 1'b1;
                            ctl_next.write_strobe = 1'b0;
                            state_next            = ST_IDLE;
                        end
                        else
                            state_next = ST_PROG;
                    end
                end
            end
            ST_ERASE:
            begin
                cnt_next = cnt_reg + 32'h1;
                if (cnt_reg == 32'(OP_CYCLES - 1))
                begin
                    ctl_next.erase_select = 1'b0;
                    ctl_next.write_strobe = 1'b0;
                    done_next             = 1'b1;
                    state_next            = ST_IDLE;
                end
            end
            ST_PROG:
            begin
                cnt_next = cnt_reg + 32'h1;
                if (cnt_reg < 32'(LATCHES))
                begin
                    // whole block, one word per cycle, never past the boundary
                    pg_cmd_next.valid = 1'b1;
                    pg_cmd_next.addr  = {full_addr[14:LW], cnt_reg[LW-1:0]};
                    pg_cmd_next.data  = latch_reg[cnt_reg[LW-1:0]];
                end
                if (cnt_reg == 32'(OP_CYCLES - 1))
                begin
                    latch_next = '{default: `NVM_LATCH_RST};
                    ctl_next.write_strobe = 1'b0;
                    done_next             = 1'b1;
                    state_next            = ST_IDLE;
                end
            end
            default:
                state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        wp_meta_reg <= WRITE_PROTECT;
        wp_sync_reg <= wp_meta_reg;
        cp_meta_reg <= CODE_PROTECT;
        cp_sync_reg <= cp_meta_reg;
        if (SYS_RST)
        begin
            state_reg   <= ST_IDLE;
            ctl_reg     <= nvm_control_t'(`NVM_CONTROL_RST);
            addr_lo_reg <= 8'h00;
            addr_hi_reg <= 7'h00;
            data_lo_reg <= 8'h00;
            data_hi_reg <= 6'h00;
            unlock_reg  <= 2'h0;
            done_reg    <= 1'b0;
            refused_reg <= 1'b0;
            cnt_reg     <= 32'h0;
            prdata_reg  <= 32'h0;
            rd_cmd_reg  <= '0;
            pg_cmd_reg  <= '0;
            erase_reg   <= 1'b0;
            latch_reg   <= '{default: `NVM_LATCH_RST};
        end
        else
        begin
            state_reg   <= state_next;
            ctl_reg     <= ctl_next;
            addr_lo_reg <= addr_lo_next;
            addr_hi_reg <= addr_hi_next;
            data_lo_reg <= data_lo_next;
            data_hi_reg <= data_hi_next;
            unlock_reg  <= unlock_next;
            done_reg    <= done_next;
            refused_reg <= refused_next;
            cnt_reg     <= cnt_next;
            prdata_reg  <= prdata_next;
            rd_cmd_reg  <= rd_cmd_next;
            pg_cmd_reg  <= pg_cmd_next;
            erase_reg   <= erase_next;
            latch_reg   <= latch_next;
        end
    end

endmodule : flash_self_program_sequencer

// [flash_self_program_sequencer_tb_top.sv]
`include "flash_seq_map.svh"
module flash_self_program_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLK           = 1'b0;
    logic        SYS_RST       = 1'b1;
    logic        PSEL          = 1'b0;
    logic        PENABLE       = 1'b0;
    logic        PWRITE        = 1'b0;
    logic [7:0]  PADDR         = 8'h00;
    logic [31:0] PWDATA        = 32'h0;
    logic [1:0]  WRITE_PROTECT = 2'h3;
    logic        CODE_PROTECT  = 1'b0;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    logic        ARRAY_RD;
    logic        ARRAY_PROG;
    logic        ARRAY_ERASE;
    logic [14:0] ARRAY_ADDR;
    logic [13:0] ARRAY_WDATA;
    logic [13:0] ARRAY_RDATA;
    logic        CPU_STALL;
    logic [64:0] notes [$];
    logic [64:0] note;
    logic [31:0] last_rd;
    logic [13:0] shadow [32];
    logic [14:0] base;
    logic [14:0] base2;
    int          fail_count      = 0;
    int          samples_checked = 0;
    int          cycles          = 0;
    always #5 CLK = ~CLK;
    flash_self_program_sequencer #(
        .OP_CYCLES(40),
        .LATCHES  (32)
    ) dut (
        .CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .WRITE_PROTECT(WRITE_PROTECT),
        .CODE_PROTECT(CODE_PROTECT), .ARRAY_RD(ARRAY_RD), .ARRAY_PROG(ARRAY_PROG),
        .ARRAY_ERASE(ARRAY_ERASE), .ARRAY_ADDR(ARRAY_ADDR),
        .ARRAY_WDATA(ARRAY_WDATA), .ARRAY_RDATA(ARRAY_RDATA), .CPU_STALL(CPU_STALL)
    );
    flash_array_model farray (
        .clk(CLK), .rd(ARRAY_RD), .prog(ARRAY_PROG), .erase(ARRAY_ERASE),
        .addr(ARRAY_ADDR), .wdata(ARRAY_WDATA), .rdata(ARRAY_RDATA)
    );
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL    <= 1'b1;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        @(posedge CLK);
        while (PREADY !== 1'b1)
            @(posedge CLK);
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                      input logic err);
        notes.push_back({err, m, e & m});
        xfer(1'b0, a, 32'h0);
    endtask : rd
    task automatic set_addr(input logic [14:0] a);
        wr(`NVM_ADDR_LOW_OFS, {24'h0, a[7:0]});
        wr(`NVM_ADDR_HIGH_OFS, {25'h0, a[14:8]});
    endtask : set_addr
    task automatic go(input logic [7:0] ctl);
        wr(`NVM_CONTROL_OFS, {24'h0, ctl & 8'hFD});
        wr(`NVM_UNLOCK_OFS, 32'h55);
        wr(`NVM_UNLOCK_OFS, 32'hAA);
        wr(`NVM_CONTROL_OFS, {24'h0, ctl});
    endtask : go
    task automatic rd_word(input logic [14:0] a, input logic [13:0] e);
        set_addr(a);
        wr(`NVM_CONTROL_OFS, 32'h81);
        repeat (2) @(posedge CLK);
        rd(`NVM_DATA_LOW_OFS, {24'h0, e[7:0]}, 32'hFF, 1'b0);
        rd(`NVM_DATA_HIGH_OFS, {26'h0, e[13:8]}, 32'h3F, 1'b0);
    endtask : rd_word
    task automatic wait_idle();
        do
        begin
            rd(`NVM_STATUS_OFS, 32'h0, 32'h0, 1'b0);
            #1;
        end while (last_rd[`STS_BUSY_BIT] !== 1'b0);
    endtask : wait_idle
    task automatic prog_blk(input logic [14:0] b, input int n);
        logic [13:0] d;
        for (int i = 0; i < 32; i++)
            shadow[i] = 14'h3FFF;
        for (int i = 0; i < n; i++)
        begin
            d = 14'($urandom);
            shadow[i] = d;
            set_addr(b + 15'(i));
            wr(`NVM_DATA_LOW_OFS, {24'h0, d[7:0]});
            wr(`NVM_DATA_HIGH_OFS, {26'h0, d[13:8]});
            go(i == n - 1 ? 8'h86 : 8'hA6);
            repeat (4) @(negedge CLK);
            check("stall", {31'h0, CPU_STALL}, {31'h0, i == n - 1});
        end
        wait_idle();
        rd(`NVM_STATUS_OFS, 32'h1, 32'h3, 1'b0);
        wr(`NVM_STATUS_OFS, 32'h1);
        rd(`NVM_STATUS_OFS, 32'h0, 32'h3, 1'b0);
        for (int i = 0; i < 32; i++)
            rd_word(b + 15'(i), shadow[i]);
    endtask : prog_blk
    always @(posedge CLK)
        if (PSEL && PENABLE && PREADY && !PWRITE)
        begin
            note = notes.pop_front();
            last_rd = PRDATA;
            check("prdata", PRDATA & note[63:32], note[31:0]);
            check("pslverr", {31'h0, PSLVERR}, {31'h0, note[64]});
        end
    always @(posedge CLK)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            fail_count++;
            report_and_stop();
        end
    end
    initial
    begin
        void'($urandom(32'hE7E97EB3));
        repeat (2) @(posedge CLK);
        SYS_RST <= 1'b0;
        rd(`NVM_CONTROL_OFS, 32'h0, 32'hFF, 1'b0);
        rd(`NVM_UNLOCK_OFS, 32'h0, 32'hFF, 1'b0);
        rd(8'h1C, 32'h0, 32'hFFFFFFFF, 1'b1);
        CODE_PROTECT <= 1'($urandom);
        repeat (4) @(posedge CLK);
        rd(`NVM_STATUS_OFS, {26'h0, CODE_PROTECT, 5'h18}, 32'h38, 1'b0);
        $display("test reset done");
        base = {10'($urandom), 5'h00};
        prog_blk(base, $urandom_range(2, 31));
        base2 = base ^ 15'h0020;
        prog_blk(base2, 1);
        $display("test program done");
        set_addr(base | 15'($urandom_range(0, 31)));
        go(8'h96);
        rd(`NVM_CONTROL_OFS, 32'h12, 32'h12, 1'b0);
        wr(`NVM_CONTROL_OFS, 32'h80);
        wait_idle();
        rd(`NVM_CONTROL_OFS, 32'h0, 32'h12, 1'b0);
        rd_word(base, 14'h3FFF);
        rd_word(base + 15'd31, 14'h3FFF);
        rd_word(base2, shadow[0]);
        $display("test erase done");
        wr(`NVM_STATUS_OFS, 32'h3);
        wr(`NVM_CONTROL_OFS, 32'h94);
        wr(`NVM_CONTROL_OFS, 32'h96);
        rd(`NVM_CONTROL_OFS, 32'h0, 32'h2, 1'b0);
        wr(`NVM_CONTROL_OFS, 32'h80);
        go(8'h92);
        rd(`NVM_CONTROL_OFS, 32'h0, 32'h2, 1'b0);
        WRITE_PROTECT <= 2'h0;
        set_addr(base2);
        go(8'h96);
        repeat (4) @(posedge CLK);
        rd(`NVM_STATUS_OFS, 32'h2, 32'h3, 1'b0);
        rd_word(base2, shadow[0]);
        for (int k = 1; k <= 2; k++)
        begin
            WRITE_PROTECT <= 2'(k);
            wr(`NVM_STATUS_OFS, 32'h3);
            set_addr((k == 1 ? `NVM_WP_HALF_LIMIT : `NVM_WP_LOW_LIMIT) - 15'h0020);
            go(8'h96);
            repeat (4) @(posedge CLK);
            rd(`NVM_STATUS_OFS, 32'h2, 32'h3, 1'b0);
            set_addr(k == 1 ? `NVM_WP_HALF_LIMIT : `NVM_WP_LOW_LIMIT);
            go(8'h96);
            wait_idle();
            rd(`NVM_STATUS_OFS, 32'h1, 32'h1, 1'b0);
        end
        $display("test refuse done");
        report_and_stop();
    end
endmodule : flash_self_program_sequencer_tb_top
bind flash_self_program_sequencer flash_seq_sva #(
    .OP_CYCLES(OP_CYCLES),
    .LATCHES  (LATCHES)
) chk (
    .CLK(CLK), .SYS_RST(SYS_RST), .ARRAY_RD(ARRAY_RD), .ARRAY_PROG(ARRAY_PROG),
    .ARRAY_ERASE(ARRAY_ERASE), .ARRAY_ADDR(ARRAY_ADDR), .CPU_STALL(CPU_STALL)
);

// [flash_seq_map.svh]
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH

// register byte offsets
`define NVM_ADDR_LOW_OFS    8'h00
`define NVM_ADDR_HIGH_OFS   8'h04
`define NVM_DATA_LOW_OFS    8'h08
`define NVM_DATA_HIGH_OFS   8'h0C
`define NVM_CONTROL_OFS     8'h10
`define NVM_UNLOCK_OFS      8'h14
`define NVM_STATUS_OFS      8'h18

// control field positions
`define CTL_READ_STROBE_BIT   0
`define CTL_WRITE_STROBE_BIT  1
`define CTL_WRITE_ENABLE_BIT  2
`define CTL_ERASE_SELECT_BIT  4
`define CTL_LATCH_ONLY_BIT    5
`define CTL_CONFIG_SPACE_BIT  6
`define CTL_PROG_MEM_BIT      7

// status field positions
`define STS_COMPLETE_BIT   0
`define STS_REFUSED_BIT    1
`define STS_BUSY_BIT       2
`define STS_PROTECT_LSB    3
`define STS_CODE_PROT_BIT  5

// reset values
`define NVM_CONTROL_RST    8'h00
`define NVM_LATCH_RST      14'h3FFF

// unlock pattern
`define NVM_UNLOCK_FIRST   8'h55
`define NVM_UNLOCK_SECOND  8'hAA

// write-protect segment limits (word addresses)
`define NVM_WP_LOW_LIMIT   15'h0200
`define NVM_WP_HALF_LIMIT  15'h2000

// timing
`define NVM_CLK_MHZ        100
`define NVM_OP_TIME_US     2000
`define NVM_OP_CYCLES      (`NVM_OP_TIME_US * `NVM_CLK_MHZ)
`define NVM_SETUP_CYCLES   2
`define NVM_LATCH_COUNT    32

`endif

// [flash_seq_pkg.sv]
package flash_seq_pkg;

    typedef struct packed {
        logic program_memory_select;
        logic config_space_select;
        logic latch_only_select;
        logic erase_select;
        logic spare;
        logic write_enable_bit;
        logic write_strobe;
        logic read_strobe;
    } nvm_control_t;

    typedef struct packed {
        logic        valid;
        logic [14:0] addr;
        logic [13:0] data;
    } array_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_ARRAY,
        ST_RD_DONE,
        ST_SETUP,
        ST_ERASE,
        ST_PROG
    } seq_state_t;

endpackage : flash_seq_pkg

// [flash_seq_sva.sv]
module flash_seq_sva #(
    parameter int OP_CYCLES = 40,
    parameter int LATCHES   = 32
)(
    input wire logic        CLK,
    input wire logic        SYS_RST,
    input wire logic        ARRAY_RD,
    input wire logic        ARRAY_PROG,
    input wire logic        ARRAY_ERASE,
    input wire logic [14:0] ARRAY_ADDR,
    input wire logic        CPU_STALL
);
    timeunit 1ns;
    timeprecision 1ps;
    int stall_cnt_reg;
    int stall_cnt_next;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);
    always_comb
        stall_cnt_next = CPU_STALL ? stall_cnt_reg + 1 : 0;
    always_ff @(posedge CLK)
        stall_cnt_reg <= SYS_RST ? 0 : stall_cnt_next;
    a_read_single: assert property (
        ARRAY_RD |=> !ARRAY_RD)
        else $error("array read longer than one cycle");
    a_read_no_stall: assert property (
        ARRAY_RD |-> !CPU_STALL [*3])
        else $error("stall around array read");
    a_erase_aligned: assert property (
        ARRAY_ERASE |-> ARRAY_ADDR[4:0] == 5'h00)
        else $error("erase row not aligned");
    a_erase_stalls: assert property (
        ARRAY_ERASE |-> ##[0:2] CPU_STALL)
        else $error("erase without stall");
    a_prog_in_stall: assert property (
        ARRAY_PROG |-> CPU_STALL)
        else $error("program outside stall");
    a_prog_start: assert property (
        $rose(ARRAY_PROG) |-> ARRAY_ADDR[4:0] == 5'h00)
        else $error("block program not aligned");
    a_prog_burst: assert property (
        ARRAY_PROG && ARRAY_ADDR[4:0] != 5'h1F |=>
        ARRAY_PROG && ARRAY_ADDR == $past(ARRAY_ADDR) + 15'h1)
        else $error("block program gap");
    a_prog_no_cross: assert property (
        ARRAY_PROG && ARRAY_ADDR[4:0] == 5'h1F |=> !ARRAY_PROG)
        else $error("program crosses block");
    a_stall_cause: assert property (
        $rose(CPU_STALL) |-> ##[0:2] (ARRAY_ERASE || ARRAY_PROG))
        else $error("stall without array operation");
    a_stall_length: assert property (
        CPU_STALL ##1 !CPU_STALL |-> stall_cnt_reg == OP_CYCLES)
        else $error("stall length wrong");
endmodule : flash_seq_sva
